// ---- dc_diag_pkg.sv ----
// Package with constants and carrier types for the DC load diagnostic sequencer
package dc_diag_pkg;

	localparam int NUM_CH = 4;
	localparam int CLK_HZ = 125000000;

	// APB register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATE_REQ = 8'h04;
	localparam logic [7:0] ADDR_STATE_RB = 8'h08;
	localparam logic [7:0] ADDR_REPORT_12 = 8'h0C;
	localparam logic [7:0] ADDR_REPORT_34 = 8'h10;
	localparam logic [7:0] ADDR_SL_THRESH = 8'h14;
	localparam logic [7:0] ADDR_LO_ENABLE = 8'h18;

	// Control register field positions
	localparam int CTRL_DC_EN_BIT = 0;
	localparam int CTRL_AC_EN_BIT = 1;
	localparam int CTRL_SKIP_BIT = 2;
	localparam int CTRL_CANCEL_BIT = 3;

	// Reset values
	localparam logic [3:0] CTRL_RESET = 4'h1;
	localparam logic [7:0] SL_THRESH_RESET = 8'h10;
	localparam logic [3:0] LO_ENABLE_RESET = 4'h0;

	// Channel state request codes
	localparam logic [1:0] REQ_PLAY = 2'h0;
	localparam logic [1:0] REQ_HIZ = 2'h1;
	localparam logic [1:0] REQ_MUTE = 2'h2;
	localparam logic [1:0] REQ_DIAG = 2'h3;

	// Channel state readback codes
	localparam logic [2:0] RB_PLAY = 3'h0;
	localparam logic [2:0] RB_HIZ = 3'h1;
	localparam logic [2:0] RB_MUTE = 3'h2;
	localparam logic [2:0] RB_DIAG = 3'h3;

	// Fault report field positions within a channel nibble
	localparam int FLT_S2G = 0;
	localparam int FLT_S2P = 1;
	localparam int FLT_SL = 2;
	localparam int FLT_OL = 3;

	// Timing
	localparam int POR_MS = 10;
	localparam int RETEST_MS = 750;
	localparam int STEP_US = 100;
	localparam int POR_CYCLES = CLK_HZ / 1000 * POR_MS;
	localparam int RETEST_CYCLES = CLK_HZ / 1000 * RETEST_MS;
	localparam int STEP_CYCLES = CLK_HZ / 1000000 * STEP_US;

	// Sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_S2G = 7'h02,
		ST_S2P = 7'h04,
		ST_SL = 7'h08,
		ST_OL = 7'h10,
		ST_LO = 7'h20,
		ST_DONE = 7'h40
	} diag_state_t;

	// Per-channel analog comparator results
	typedef struct packed {
		logic gnd_short;
		logic sup_short;
		logic [7:0] load_ohm;
		logic open_load;
		logic line_load;
	} sense_t;

	// Per-channel state
	typedef struct packed {
		diag_state_t st;
		logic [3:0] fault;
		logic pass;
		logic init_pass;
		logic [2:0] rb;
		logic retest_armed;
		logic [29:0] retest_cnt;
		logic [1:0] req_prev;
	} chan_t;

endpackage : dc_diag_pkg

// ---- dc_load_diagnostic_sequencer.sv ----
// DC load diagnostic sequencer with APB register access
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none

module dc_load_diagnostic_sequencer import dc_diag_pkg::*; #(
	parameter int POR_WAIT = POR_CYCLES,
	parameter int RETEST_WAIT = RETEST_CYCLES,
	parameter int STEP_WAIT = STEP_CYCLES
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Pins
	input wire logic standby_in,
	input wire logic supply_ok_in,
	input wire logic fault_in,
	output logic fault_out,
	output logic fault_oe_out,
	// Analog test front end
	input wire sense_t [NUM_CH-1:0] sense_in,
	output logic [NUM_CH-1:0] test_drive_out,
	// Power stage permission and status
	output logic [NUM_CH-1:0] play_allow_out,
	output logic [NUM_CH-1:0] load_check_pass_flag_out,
	output logic ac_diag_enable_out
);

	typedef struct packed {
		logic [3:0] ctrl;
		logic [2*NUM_CH-1:0] channel_state_request;
		logic [8*NUM_CH-1:0] sl_thresh;
		logic [NUM_CH-1:0] lo_enable;
		logic [31:0] por_cnt;
		logic por_done;
		logic [1:0] stby_sync;
		logic stby_prev;
		logic auto_used;
		logic [31:0] step_cnt;
		chan_t [NUM_CH-1:0] ch;
		// Marks a run launched by the standby edge, so its result can waive transition runs
		logic [NUM_CH-1:0] auto_run;
		logic [31:0] prdata;
	} state_t;

	state_t s_q;
	state_t s_d;
	sense_t [NUM_CH-1:0] sense_q1;
	sense_t [NUM_CH-1:0] sense_q2;
	logic [1:0] supply_sync_q;

	function automatic logic [1:0] req_of(input logic [2*NUM_CH-1:0] v, input int i);
		req_of = v[2*i +: 2];
	endfunction : req_of

	function automatic logic [3:0] nib(input chan_t c);
		nib = c.fault;
	endfunction : nib

	// Sense lines come from analog comparators, so they are synchronised first
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sense_q1 <= '0;
			sense_q2 <= '0;
			supply_sync_q <= 2'h0;
		end else begin
			sense_q1 <= sense_in;
			sense_q2 <= sense_q1;
			supply_sync_q <= {supply_sync_q[0], supply_ok_in};
		end
	end

	logic step_tick;
	logic apb_wr;
	logic apb_rd;
	logic stby_rise;
	logic dc_en;
	logic skip;
	logic cancel;
	logic [1:0] rq;
	logic [1:0] rq_prev;
	logic start;
	logic auto_start;
	logic [3:0] f;

	always_comb begin
		s_d = s_q;
		apb_wr = psel_in && penable_in && pwrite_in;
		apb_rd = psel_in && !penable_in && !pwrite_in;
		dc_en = s_q.ctrl[CTRL_DC_EN_BIT];
		skip = s_q.ctrl[CTRL_SKIP_BIT];
		cancel = s_q.ctrl[CTRL_CANCEL_BIT];
		step_tick = (s_q.step_cnt == 32'(STEP_WAIT - 1));
		rq = 2'h0;
		rq_prev = 2'h0;
		start = 1'b0;
		auto_start = 1'b0;
		f = 4'h0;

		// Power-on initialisation holds the fault pin low until done
		if (!s_q.por_done) begin
			s_d.por_cnt = s_q.por_cnt + 32'h1;
			if (s_q.por_cnt == 32'(POR_WAIT - 1)) begin
				s_d.por_done = 1'b1;
			end
		end

		s_d.stby_sync = {s_q.stby_sync[0], standby_in};
		s_d.stby_prev = s_q.stby_sync[1];
		stby_rise = s_q.por_done && s_q.stby_sync[1] && !s_q.stby_prev;

		// Slow step clock for test phases, free-running and never gated
		s_d.step_cnt = step_tick ? 32'h0 : s_q.step_cnt + 32'h1;

		// APB writes; register content only changes in the access phase
		if (apb_wr) begin
			case (paddr_in)
				ADDR_CTRL: s_d.ctrl = pwdata_in[3:0];
				ADDR_STATE_REQ: s_d.channel_state_request = pwdata_in[2*NUM_CH-1:0];
				ADDR_SL_THRESH: s_d.sl_thresh = pwdata_in[8*NUM_CH-1:0];
				ADDR_LO_ENABLE: s_d.lo_enable = pwdata_in[NUM_CH-1:0];
				default: ;
			endcase
		end

		for (int i = 0; i < NUM_CH; i++) begin
			rq = req_of(s_d.channel_state_request, i);
			rq_prev = s_q.ch[i].req_prev;
			s_d.ch[i].req_prev = rq;
			start = 1'b0;
			auto_start = 1'b0;

			// Automatic run on first standby rise, unless cancelled
			if (stby_rise && !s_q.auto_used && !cancel && dc_en) begin
				start = 1'b1;
				auto_start = 1'b1;
			end
			// Leaving high-impedance for mute or play
			if (s_q.stby_sync[1] && !skip && dc_en && rq_prev == REQ_HIZ
					&& (rq == REQ_PLAY || rq == REQ_MUTE) && !s_q.ch[i].init_pass) begin
				start = 1'b1;
			end
			// Manual run when the request changes to diagnostic from any other request
			if (rq == REQ_DIAG && rq_prev != REQ_DIAG) begin
				start = 1'b1;
			end
			// Retest of a faulted channel, own timer per channel
			if (s_q.ch[i].retest_armed) begin
				if (!dc_en) begin
					s_d.ch[i].retest_armed = 1'b0;
				end else if (s_q.ch[i].retest_cnt == 30'(RETEST_WAIT - 1)) begin
					s_d.ch[i].retest_armed = 1'b0;
					start = 1'b1;
				end else begin
					s_d.ch[i].retest_cnt = s_q.ch[i].retest_cnt + 30'h1;
				end
			end

			case (s_q.ch[i].st)
				ST_IDLE: begin
					if (start && supply_sync_q[1]) begin
						s_d.ch[i].st = ST_S2G;
						s_d.ch[i].fault = 4'h0;
						s_d.ch[i].pass = 1'b0;
						s_d.ch[i].rb = RB_DIAG;
						s_d.ch[i].retest_armed = 1'b0;
						s_d.auto_run[i] = auto_start;
					end else if (!s_q.ch[i].pass && rq != REQ_DIAG) begin
						s_d.ch[i].rb = RB_HIZ;
					end else if (rq == REQ_PLAY) begin
						s_d.ch[i].rb = RB_PLAY;
					end else if (rq == REQ_MUTE) begin
						s_d.ch[i].rb = RB_MUTE;
					end else if (rq == REQ_HIZ) begin
						s_d.ch[i].rb = RB_HIZ;
					end
				end
				ST_S2G: if (step_tick) begin
					if (sense_q2[i].gnd_short) s_d.ch[i].fault[FLT_S2G] = 1'b1;
					s_d.ch[i].st = ST_S2P;
				end
				ST_S2P: if (step_tick) begin
					if (sense_q2[i].sup_short) s_d.ch[i].fault[FLT_S2P] = 1'b1;
					s_d.ch[i].st = ST_SL;
				end
				ST_SL: if (step_tick) begin
					if (sense_q2[i].load_ohm < s_q.sl_thresh[8*i +: 8]) begin
						s_d.ch[i].fault[FLT_SL] = 1'b1;
					end
					s_d.ch[i].st = ST_OL;
				end
				ST_OL: if (step_tick) begin
					if (sense_q2[i].open_load) begin
						s_d.ch[i].fault[FLT_OL] = 1'b1;
						// Line test may pop, so it only runs when asked for
						s_d.ch[i].st = s_q.lo_enable[i] ? ST_LO : ST_DONE;
					end else begin
						s_d.ch[i].st = ST_DONE;
					end
				end
				ST_LO: if (step_tick) begin
					// A line-output load clears the open-load flag, so it reports no open-load fault
					if (sense_q2[i].line_load) s_d.ch[i].fault[FLT_OL] = 1'b0;
					s_d.ch[i].st = ST_DONE;
				end
				ST_DONE: begin
					f = s_q.ch[i].fault;
					s_d.ch[i].st = ST_IDLE;
					s_d.ch[i].rb = RB_HIZ;
					if (f == 4'h0) begin
						s_d.ch[i].pass = 1'b1;
						if (s_q.auto_run[i]) s_d.ch[i].init_pass = 1'b1;
					end else begin
						s_d.ch[i].pass = 1'b0;
						s_d.ch[i].retest_armed = 1'b1;
						s_d.ch[i].retest_cnt = 30'h0;
					end
				end
				default: s_d.ch[i].st = ST_IDLE;
			endcase
		end
		if (stby_rise) s_d.auto_used = 1'b1;

		// Read data captured in the setup phase, held for the access phase
		if (apb_rd) begin
			s_d.prdata = 32'h0;
			case (paddr_in)
				ADDR_CTRL: s_d.prdata[3:0] = s_q.ctrl;
				ADDR_STATE_REQ: s_d.prdata[2*NUM_CH-1:0] = s_q.channel_state_request;
				ADDR_STATE_RB: begin
					for (int i = 0; i < NUM_CH; i++) begin
						s_d.prdata[4*i +: 3] = s_q.ch[i].rb;
						s_d.prdata[16+i] = s_q.ch[i].pass;
					end
				end
				ADDR_REPORT_12: s_d.prdata[7:0] = {nib(s_q.ch[1]), nib(s_q.ch[0])};
				ADDR_REPORT_34: s_d.prdata[7:0] = {nib(s_q.ch[3]), nib(s_q.ch[2])};
				ADDR_SL_THRESH: s_d.prdata[8*NUM_CH-1:0] = s_q.sl_thresh;
				ADDR_LO_ENABLE: s_d.prdata[NUM_CH-1:0] = s_q.lo_enable;
				default: s_d.prdata = 32'h0;
			endcase
		end
	end

	// Every register returns to its default under power-on reset
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= '0;
			s_q.ctrl <= CTRL_RESET;
			s_q.channel_state_request <= {NUM_CH{REQ_HIZ}};
			s_q.sl_thresh <= {NUM_CH{SL_THRESH_RESET}};
			s_q.lo_enable <= LO_ENABLE_RESET;
			for (int i = 0; i < NUM_CH; i++) begin
				s_q.ch[i].st <= ST_IDLE;
				s_q.ch[i].rb <= RB_HIZ;
				s_q.ch[i].req_prev <= REQ_HIZ;
			end
		end else begin
			s_q <= s_d;
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			test_drive_out[i] = (s_q.ch[i].st != ST_IDLE) && (s_q.ch[i].st != ST_DONE);
			play_allow_out[i] = s_q.ch[i].pass;
			load_check_pass_flag_out[i] = s_q.ch[i].pass;
		end
	end

	// Unmapped addresses read zero and never error
	assign prdata_out = s_q.prdata;
	assign pready_out = 1'b1;
	assign pslverr_out = 1'b0;
	assign fault_out = 1'b0;
	assign fault_oe_out = !s_q.por_done;
	assign ac_diag_enable_out = s_q.ctrl[CTRL_AC_EN_BIT];

endmodule : dc_load_diagnostic_sequencer

`default_nettype wire

// ---- dc_diag_asserts.sv ----
// Assertion checker for the DC load diagnostic sequencer
`timescale 1ns/100ps
`default_nettype none
module dc_diag_asserts import dc_diag_pkg::*; #(
	parameter int POR_WAIT = 20
) (
	// Clock, reset and inputs
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic supply_ok_in,
	// Outputs
	input wire logic fault_out,
	input wire logic fault_oe_out,
	input wire logic [NUM_CH-1:0] test_drive_out,
	input wire logic [NUM_CH-1:0] play_allow_out,
	input wire logic [NUM_CH-1:0] load_check_pass_flag_out,
	input wire logic ac_diag_enable_out
);
	int cnt_q;
	logic [NUM_CH-1:0] ran_q;
	// Saturates so a long run cannot wrap it
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q <= 0;
			ran_q <= '0;
		end else begin
			if (cnt_q < POR_WAIT + 9)
				cnt_q <= cnt_q + 1;
			ran_q <= ran_q | test_drive_out;
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	sequence ctrl_wr;
		psel_in && penable_in && pwrite_in && paddr_in == ADDR_CTRL;
	endsequence
	chk_reset_off: assert property (
		$fell(rst_in) |-> !ac_diag_enable_out && load_check_pass_flag_out == '0)
		else $error("bad reset value");
	chk_ac_write: assert property (
		ctrl_wr |-> ##2 ac_diag_enable_out == $past(pwdata_in[CTRL_AC_EN_BIT], 2))
		else $error("ac enable wrong");
	chk_por_hold: assert property (
		cnt_q < POR_WAIT - 1 |-> fault_oe_out) else $error("fault released early");
	chk_por_release: assert property (
		cnt_q > POR_WAIT + 2 |-> !fault_oe_out) else $error("fault not released");
	chk_fault_low: assert property (!fault_out) else $error("fault pin high");
	chk_play_gate: assert property (
		(play_allow_out & ~load_check_pass_flag_out) == '0) else $error("play without pass");
	chk_pass_cause: assert property (
		(load_check_pass_flag_out & ~$past(load_check_pass_flag_out) & ~ran_q) == '0)
		else $error("pass without run");
	chk_supply_gate: assert property (
		!supply_ok_in [*4] |=> (test_drive_out & ~$past(test_drive_out)) == '0)
		else $error("run without supply");
endmodule : dc_diag_asserts
bind dc_load_diagnostic_sequencer dc_diag_asserts #(.POR_WAIT(POR_WAIT)) asserts_inst (.*);
`default_nettype wire

// ---- load_model.sv ----
// Speaker load model feeding the analog test front end
`timescale 1ns/100ps
`default_nettype none
module load_model import dc_diag_pkg::*; (
	// Kind per channel: 0 good 1 ground 2 supply 3 shorted 4 open 5 line
	input wire logic [NUM_CH-1:0][2:0] kind_in,
	input wire logic [7:0] good_ohm_in,
	// Comparator results
	output var sense_t [NUM_CH-1:0] sense_out
);
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			sense_out[i].gnd_short = kind_in[i] == 3'h1;
			sense_out[i].sup_short = kind_in[i] == 3'h2;
			sense_out[i].load_ohm = kind_in[i] == 3'h3 ? 8'h04 : good_ohm_in;
			sense_out[i].open_load = kind_in[i] >= 3'h4;
			sense_out[i].line_load = kind_in[i] == 3'h5;
		end
	end
endmodule : load_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench for the DC load diagnostic sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench import dc_diag_pkg::*; ;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic standby_in = 1'b0;
	logic supply_ok_in = 1'b1;
	logic [7:0] paddr_in = 8'h00;
	logic [7:0] good = 8'h40;
	logic [31:0] pwdata_in = 32'h0;
	logic [NUM_CH-1:0][2:0] kind = '0;
	logic [3:0] lo = 4'h0;
	logic [31:0] prdata_out, rdat;
	logic pready_out, pslverr_out, fault_out, fault_oe_out, ac_diag_enable_out;
	logic [3:0] test_drive_out, play_allow_out, load_check_pass_flag_out, seen;
	sense_t [NUM_CH-1:0] sense_in;
	wire logic fault_in;
	int n_errors = 0;
	int samples_checked = 0;
	// Open-drain fault line with its pull-up
	assign fault_in = fault_oe_out ? fault_out : 1'b1;
	always #4 core_clk_in = ~core_clk_in;
	dc_load_diagnostic_sequencer #(.POR_WAIT(20), .RETEST_WAIT(50), .STEP_WAIT(4))
		dc_load_diagnostic_sequencer_inst (.*);
	load_model load_model_inst (.kind_in(kind), .good_ohm_in(good), .sense_out(sense_in));
	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge core_clk_in);
		penable_in <= 1'b1;
		do @(posedge core_clk_in); while (pready_out !== 1'b1);
		rdat = prdata_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		// One idle edge so a following call never re-drives psel in the same step
		@(posedge core_clk_in);
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask : rd
	// Waits for a run on the masked channels, then for its end
	task automatic run_wait(input logic [3:0] m, input int lim);
		seen = 4'h0;
		for (int k = 0; k < lim && (test_drive_out & m) == 4'h0; k++)
			@(posedge core_clk_in);
		while ((test_drive_out & m) != 4'h0) begin
			seen |= test_drive_out;
			@(posedge core_clk_in);
		end
		repeat (2) @(posedge core_clk_in);
	endtask : run_wait
	function automatic logic [3:0] nib(input logic [2:0] k, input logic l);
		logic [3:0] t [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h8, 4'h0, 4'h0};
		return (k == 3'h5 && l) ? 4'h0 : t[k];
	endfunction : nib
	function automatic logic [31:0] rep(input int c);
		return {24'h0, nib(kind[c+1], lo[c+1]), nib(kind[c], lo[c])};
	endfunction : rep
	function automatic logic [31:0] pexp();
		pexp = 32'h0;
		for (int i = 0; i < NUM_CH; i++)
			pexp[i] = kind[i] == 3'h0;
	endfunction : pexp
	initial begin
		void'($urandom(14539));
		repeat (20) @(posedge core_clk_in);
		rst_in <= 1'b0;
		supply_ok_in <= 1'b0;
		good <= 8'h20 + 8'($urandom_range(8'h5F));
		repeat (6) @(posedge core_clk_in);
		supply_ok_in <= 1'b1;
		rd(ADDR_CTRL, {28'h0, CTRL_RESET});
		rd(ADDR_STATE_REQ, 32'h55);
		rd(ADDR_SL_THRESH, {4{SL_THRESH_RESET}});
		rd(8'h1C, 32'h0);
		$display("registers done");
		while (fault_oe_out !== 1'b0) @(posedge core_clk_in);
		chk(32'(fault_in), 32'h1);
		kind <= {3'h3, 3'h2, 3'h1, 3'h0};
		standby_in <= 1'b1;
		run_wait(4'hF, 20);
		chk(32'(load_check_pass_flag_out), pexp());
		rd(ADDR_REPORT_12, rep(0));
		rd(ADDR_REPORT_34, rep(2));
		$display("auto run done");
		kind[1] <= 3'h0;
		run_wait(4'h2, 80);
		chk(32'(load_check_pass_flag_out), pexp());
		rd(ADDR_REPORT_12, rep(0));
		$display("retest done");
		xfer(1'b1, ADDR_STATE_REQ, 32'h50);
		run_wait(4'h2, 20);
		chk(32'(seen[1:0]), 32'h2);
		chk(32'(play_allow_out[1:0]), 32'h3);
		$display("transition done");
		lo <= 4'h4;
		kind[3:2] <= {3'h4, 3'h5};
		xfer(1'b1, ADDR_LO_ENABLE, 32'h4);
		run_wait(4'hC, 80);
		xfer(1'b1, ADDR_STATE_REQ, 32'hF0);
		run_wait(4'hC, 20);
		xfer(1'b0, ADDR_STATE_RB, 32'h0);
		chk(rdat & 32'h7700, 32'h1100);
		rd(ADDR_REPORT_34, rep(2));
		$display("manual done");
		rst_in <= 1'b1;
		standby_in <= 1'b0;
		@(posedge core_clk_in);
		rst_in <= 1'b0;
		xfer(1'b1, ADDR_CTRL, 32'h9);
		while (fault_oe_out !== 1'b0) @(posedge core_clk_in);
		standby_in <= 1'b1;
		run_wait(4'hF, 40);
		chk(32'(seen), 32'h0);
		$display("cancel done");
		stop_test();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge core_clk_in);
		n_errors++;
		$display("[ERR] %0t watchdog", $time);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
